// File: rtl/dsc_pkg.sv
// Package with constants, types and register map of the drive setpoint channel.
package dsc_pkg;

  // ****************************************
  // Widths and scaling
  // ****************************************
  localparam int SW = 16;
  localparam int FRAC = 8;
  localparam logic signed [15:0] ZERO = 16'sh0000;
  localparam logic signed [15:0] SMAX = 16'sh7FFF;
  localparam logic signed [15:0] SMIN = -16'sh7FFF;
  // Frequencies are in units of 0.1 Hz.
  localparam int MAX_FREQ_LIMIT_HZ = 650;
  localparam logic [15:0] MAX_FREQ_LIMIT = 16'h1964;
  localparam int NUM_FIXED = 7;
  localparam int CLK_MHZ = 200;
  localparam int CTRL_PERIOD_US = 8000;
  localparam int CTRL_TICK_CYCLES = CTRL_PERIOD_US * CLK_MHZ;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MAIN_SCALE = 8'h04;
  localparam logic [7:0] A_SUPP_SCALE = 8'h08;
  localparam logic [7:0] A_ACCEL = 8'h0C;
  localparam logic [7:0] A_DECEL = 8'h10;
  localparam logic [7:0] A_MAXF = 8'h14;
  localparam logic [7:0] A_ROUND = 8'h18;
  localparam logic [7:0] A_EXCIT = 8'h1C;
  localparam logic [7:0] A_LP_RAMP = 8'h20;
  localparam logic [7:0] A_LP_FILT = 8'h24;
  localparam logic [7:0] A_LP_GAIN = 8'h28;
  localparam logic [7:0] A_LP_LIM = 8'h2C;
  localparam logic [7:0] A_LP_LRT = 8'h30;
  localparam logic [7:0] A_LP_SRC = 8'h34;
  localparam logic [7:0] A_LP_FIXSEL = 8'h38;
  localparam logic [7:0] A_FIX0 = 8'h40;
  localparam logic [7:0] A_SPEED = 8'h60;
  localparam logic [7:0] A_LP_OUT = 8'h64;
  localparam logic [7:0] A_STATUS = 8'h68;
  localparam logic [7:0] A_SRC_OUT = 8'h6C;

  // Control register bits.
  localparam int C_LP_EN = 0;
  localparam int C_LP_REV_INH = 1;
  localparam int C_STOP_ROUND = 2;
  localparam int C_LP_P = 3;
  localparam int C_LP_I = 4;

  localparam logic [31:0] RST_CTRL = 32'h0000_0018;
  localparam logic signed [15:0] RST_SCALE = 16'sh0100;
  localparam logic [15:0] RST_STEP = 16'h0010;
  localparam logic [15:0] RST_MAXF = 16'h01F4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0]
  {
    FS_DIRECT = 3'h1,
    FS_DIRECT_ON = 3'h2,
    FS_BINARY_ON = 3'h4
  } dsc_fixsel_e;

  typedef struct packed
  {
    logic ramp_enable_input;
    logic ramp_run_input;
    logic ramp_setpoint_enable_input;
    logic negative_setpoint_inhibit;
    logic reverse;
    logic supp_connect;
    logic pulses_enabled;
    logic run_cmd;
  } dsc_cmd_s;

  typedef struct packed
  {
    logic raise;
    logic lower;
  } dsc_rl_s;

endpackage

// File: rtl/dsc_top.sv
// Drive setpoint channel with loop controller, raise/lower source and APB registers.
`timescale 1ns/1ps
module dsc_top
#(
  parameter int TICK_CYCLES = dsc_pkg::CTRL_TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dsc_pkg::dsc_cmd_s cmd_in,
  input wire dsc_pkg::dsc_rl_s raise_lower_in,
  input wire logic [2:0] fix_sel_in,
  input wire logic signed [15:0] main_setpoint,
  input wire logic signed [15:0] supp_setpoint,
  input wire logic signed [15:0] loop_supp_setpoint,
  input wire logic signed [15:0] loop_feedback,
  output logic signed [15:0] speed_setpoint_out,
  output logic signed [15:0] loop_output,
  output logic signed [15:0] chosen_fixed_loop_setpoint
);
  import dsc_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [12:0] sync1_q, sync2_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {cmd_in, raise_lower_in, fix_sel_in};
      sync2_q <= sync1_q;
    end
  dsc_cmd_s cmd;
  dsc_rl_s rl;
  logic [2:0] fsel;
  assign {cmd, rl, fsel} = sync2_q;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic signed [15:0] sat(input logic signed [31:0] v);
    if (v > 32'(SMAX)) sat = SMAX;
    else if (v < 32'(SMIN)) sat = SMIN;
    else sat = v[15:0];
  endfunction

  function automatic logic signed [15:0] step_to(input logic signed [15:0] cur,
    input logic signed [15:0] tgt, input logic [15:0] up, input logic [15:0] dn);
    logic signed [16:0] d;
    d = 17'(tgt) - 17'(cur);
    if (d > $signed({1'b0, up})) step_to = sat(32'(cur) + 32'(up));
    else if (-d > $signed({1'b0, dn})) step_to = sat(32'(cur) - 32'(dn));
    else step_to = tgt;
  endfunction

  function automatic logic signed [15:0] mul_q(input logic signed [15:0] a,
    input logic signed [15:0] b);
    logic signed [31:0] p;
    p = 32'(a) * 32'(b);
    mul_q = sat(p >>> FRAC);
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_q;
  logic signed [15:0] main_scale_q, supp_scale_q, lp_filt_q, lp_kp_q, lp_ki_q;
  logic signed [15:0] lp_fb_scale_q, lp_up_q, lp_lo_q, lp_init_q;
  logic [15:0] accel_q, decel_q, maxf_q, lp_rup_q, lp_rdn_q, lrt_q, src_step_q;
  logic [15:0] excit_q;
  logic [7:0] round_q [4];
  logic [5:0] fixmode_q;
  logic signed [15:0] fix_q [NUM_FIXED];
  logic signed [15:0] speed_q, lp_out_q, src_q;
  logic lp_active_q, running_q;

  logic wr_en;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && ((a <= A_LP_FIXSEL) ||
      ((a >= A_FIX0) && (a < A_FIX0 + 8'(4 * NUM_FIXED))) ||
      ((a >= A_SPEED) && (a <= A_SRC_OUT)));
  endfunction
  assign pslverr = psel && penable && !addr_ok(paddr);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_q <= RST_CTRL;
      main_scale_q <= RST_SCALE;
      supp_scale_q <= RST_SCALE;
      accel_q <= RST_STEP;
      decel_q <= RST_STEP;
      maxf_q <= RST_MAXF;
      round_q <= '{default: '0};
      excit_q <= '0;
      lp_rup_q <= RST_STEP;
      lp_rdn_q <= RST_STEP;
      lp_filt_q <= RST_SCALE;
      lp_fb_scale_q <= RST_SCALE;
      lp_kp_q <= RST_SCALE;
      lp_ki_q <= RST_STEP;
      lp_up_q <= SMAX;
      lp_lo_q <= SMIN;
      lrt_q <= RST_STEP;
      src_step_q <= RST_STEP;
      lp_init_q <= ZERO;
      fixmode_q <= '0;
      fix_q <= '{default: '0};
    end
    else if (wr_en)
    begin
      unique case (paddr)
        A_CTRL: ctrl_q <= pwdata;
        A_MAIN_SCALE: main_scale_q <= pwdata[15:0];
        A_SUPP_SCALE: supp_scale_q <= pwdata[15:0];
        A_ACCEL: accel_q <= pwdata[15:0];
        A_DECEL: decel_q <= pwdata[15:0];
        A_MAXF: maxf_q <= (pwdata[15:0] > MAX_FREQ_LIMIT) ? MAX_FREQ_LIMIT : pwdata[15:0];
        A_ROUND: round_q <= '{pwdata[7:0], pwdata[15:8], pwdata[23:16], pwdata[31:24]};
        A_EXCIT: excit_q <= pwdata[15:0];
        A_LP_RAMP: {lp_rdn_q, lp_rup_q} <= pwdata;
        A_LP_FILT: {lp_fb_scale_q, lp_filt_q} <= pwdata;
        A_LP_GAIN: {lp_ki_q, lp_kp_q} <= pwdata;
        A_LP_LIM: {lp_lo_q, lp_up_q} <= pwdata;
        A_LP_LRT: lrt_q <= pwdata[15:0];
        A_LP_SRC: {lp_init_q, src_step_q} <= pwdata;
        A_LP_FIXSEL: fixmode_q <= pwdata[5:0];
        default:
        begin
          for (int i = 0; i < NUM_FIXED; i++)
            if (paddr == A_FIX0 + 8'(4 * i))
              fix_q[i] <= pwdata[15:0];
        end
      endcase
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= '0;
      unique case (paddr)
        A_CTRL: prdata <= ctrl_q;
        A_MAIN_SCALE: prdata <= {16'h0000, main_scale_q};
        A_SUPP_SCALE: prdata <= {16'h0000, supp_scale_q};
        A_ACCEL: prdata <= {16'h0000, accel_q};
        A_DECEL: prdata <= {16'h0000, decel_q};
        A_MAXF: prdata <= {16'h0000, maxf_q};
        A_ROUND: prdata <= {round_q[3], round_q[2], round_q[1], round_q[0]};
        A_EXCIT: prdata <= {16'h0000, excit_q};
        A_LP_RAMP: prdata <= {lp_rdn_q, lp_rup_q};
        A_LP_FILT: prdata <= {lp_fb_scale_q, lp_filt_q};
        A_LP_GAIN: prdata <= {lp_ki_q, lp_kp_q};
        A_LP_LIM: prdata <= {lp_lo_q, lp_up_q};
        A_LP_LRT: prdata <= {16'h0000, lrt_q};
        A_LP_SRC: prdata <= {lp_init_q, src_step_q};
        A_LP_FIXSEL: prdata <= {26'h0, fixmode_q};
        A_SPEED: prdata <= {{16{speed_q[15]}}, speed_q};
        A_LP_OUT: prdata <= {{16{lp_out_q[15]}}, lp_out_q};
        A_STATUS: prdata <= {29'h0, running_q, lp_active_q, cmd.pulses_enabled};
        A_SRC_OUT: prdata <= {{16{src_q[15]}}, src_q};
        default:
        begin
          for (int i = 0; i < NUM_FIXED; i++)
            if (paddr == A_FIX0 + 8'(4 * i))
              prdata <= {{16{fix_q[i][15]}}, fix_q[i]};
        end
      endcase
    end

  // ****************************************
  // Control tick
  // ****************************************
  logic [31:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) tick_cnt_q <= '0;
    else tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;

  // ****************************************
  // Run edge, controller enable, excitation
  // ****************************************
  logic run_d1_q;
  logic [15:0] excit_cnt_q;
  logic ramp_ready;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      run_d1_q <= 1'b0;
      lp_active_q <= 1'b0;
      running_q <= 1'b0;
    end
    else
    begin
      run_d1_q <= cmd.run_cmd;
      running_q <= cmd.run_cmd;
      if (cmd.run_cmd && !run_d1_q)
        lp_active_q <= ctrl_q[C_LP_EN];
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) excit_cnt_q <= '0;
    else if (!cmd.pulses_enabled) excit_cnt_q <= '0;
    else if (tick && excit_cnt_q < excit_q) excit_cnt_q <= excit_cnt_q + 16'h1;
  assign ramp_ready = cmd.pulses_enabled && (excit_cnt_q >= excit_q);

  // ****************************************
  // Loop raise/lower source and fixed setpoints
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) src_q <= ZERO;
    else if (!running_q && cmd.run_cmd) src_q <= lp_init_q;
    else if (tick)
    begin
      logic signed [15:0] nv;
      nv = src_q;
      if (rl.raise && !rl.lower) nv = sat(32'(src_q) + 32'(src_step_q));
      else if (rl.lower && !rl.raise) nv = sat(32'(src_q) - 32'(src_step_q));
      if (ctrl_q[C_LP_REV_INH] && nv < ZERO) nv = ZERO;
      src_q <= nv;
    end

  logic [2:0] fix_idx;
  always_comb
  begin
    fix_idx = 3'h0;
    for (int b = 0; b < 3; b++)
    begin
      logic act;
      act = 1'b0;
      unique case (dsc_fixsel_e'(fixmode_q[2*b +: 2] == 2'h0 ? FS_DIRECT :
        fixmode_q[2*b +: 2] == 2'h1 ? FS_DIRECT_ON : FS_BINARY_ON))
        FS_DIRECT: act = fsel[b];
        FS_DIRECT_ON: act = fsel[b] && cmd.run_cmd;
        FS_BINARY_ON: act = fsel[b] && cmd.run_cmd;
      endcase
      if (act) fix_idx = (fixmode_q[2*b +: 2] == 2'h2) ? (fix_idx | 3'(1 << b)) :
        3'(b == 0 ? 1 : b == 1 ? 2 : 4);
    end
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) chosen_fixed_loop_setpoint <= ZERO;
    else chosen_fixed_loop_setpoint <= (fix_idx == 3'h0) ? ZERO : fix_q[fix_idx - 3'h1];

  // ****************************************
  // Loop controller
  // ****************************************
  logic signed [15:0] lp_rsp_q, lp_fsp_q, lp_ffb_q, lp_int_q, lim_up_q, lim_lo_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lp_rsp_q <= ZERO;
      lp_fsp_q <= ZERO;
      lp_ffb_q <= ZERO;
      lp_int_q <= ZERO;
      lim_up_q <= ZERO;
      lim_lo_q <= ZERO;
      lp_out_q <= ZERO;
    end
    else if (tick)
    begin
      logic signed [15:0] sum, err, fb, p_t, u;
      sum = sat(32'(chosen_fixed_loop_setpoint) + 32'(loop_supp_setpoint));
      lp_rsp_q <= step_to(lp_rsp_q, sum, lp_rup_q, lp_rdn_q);
      lp_fsp_q <= sat(32'(lp_fsp_q) + 32'(mul_q(lp_rsp_q - lp_fsp_q, lp_filt_q)));
      lp_ffb_q <= sat(32'(lp_ffb_q) + 32'(mul_q(loop_feedback - lp_ffb_q, lp_filt_q)));
      fb = mul_q(lp_ffb_q, lp_fb_scale_q);
      err = sat(32'(lp_fsp_q) - 32'(fb));
      lim_up_q <= step_to(lim_up_q, lp_up_q, lrt_q, lrt_q);
      lim_lo_q <= step_to(lim_lo_q, lp_lo_q, lrt_q, lrt_q);
      p_t = ctrl_q[C_LP_P] ? mul_q(err, lp_kp_q) : ZERO;
      if (ctrl_q[C_LP_I] && lp_active_q)
        lp_int_q <= sat(32'(lp_int_q) + 32'(mul_q(err, lp_ki_q)));
      u = sat(32'(p_t) + 32'(lp_int_q));
      if (!lp_active_q) u = ZERO;
      lp_out_q <= (u > lim_up_q) ? lim_up_q : (u < lim_lo_q) ? lim_lo_q : u;
    end
  assign loop_output = lp_out_q;

  // ****************************************
  // Main setpoint channel and ramp
  // ****************************************
  logic signed [15:0] rfg_q, rate_q;
  logic accel_q2;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rfg_q <= ZERO;
      rate_q <= ZERO;
      accel_q2 <= 1'b0;
      speed_q <= ZERO;
    end
    else if (tick)
    begin
      logic signed [15:0] tot, tgt, nxt, lim;
      logic [15:0] r_up, r_dn;
      tot = sat(32'(mul_q(main_setpoint, main_scale_q)) + (cmd.supp_connect ?
        32'(mul_q(supp_setpoint, supp_scale_q)) : 32'h0));
      if (cmd.reverse && !cmd.negative_setpoint_inhibit) tot = -tot;
      if (cmd.negative_setpoint_inhibit && tot < ZERO) tot = ZERO;
      tgt = cmd.ramp_setpoint_enable_input ? tot : ZERO;
      // Rounding grows the step gradually; stop rounding may be skipped.
      r_up = (round_q[0] == 8'h00) ? accel_q : 16'(rate_q) + 16'(accel_q >> 3);
      if (r_up > accel_q) r_up = accel_q;
      r_dn = (!cmd.run_cmd && accel_q2 && !ctrl_q[C_STOP_ROUND]) ? decel_q :
        (round_q[2] == 8'h00) ? decel_q : 16'(rate_q) + 16'(decel_q >> 3);
      if (r_dn > decel_q) r_dn = decel_q;
      nxt = step_to(rfg_q, tgt, r_up, r_dn);
      if (!cmd.ramp_run_input) nxt = rfg_q;
      if (!ramp_ready) nxt = ZERO;
      if (!cmd.ramp_enable_input) nxt = ZERO;
      rate_q <= (nxt > rfg_q) ? nxt - rfg_q : rfg_q - nxt;
      accel_q2 <= nxt > rfg_q;
      rfg_q <= nxt;
      lim = $signed(maxf_q);
      speed_q <= (nxt > lim) ? lim : cmd.negative_setpoint_inhibit && nxt < ZERO ? ZERO :
        (nxt < -lim) ? -lim : nxt;
    end
  assign speed_setpoint_out = speed_q;

endmodule

// File: sim/dsc_checker.sv
// Concurrent checks on the ports of the drive setpoint channel.
`timescale 1ns/1ps
module dsc_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire dsc_pkg::dsc_cmd_s cmd_in,
  input wire logic signed [15:0] speed_setpoint_out
);
  import dsc_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_ZERO_WAIT:
    assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_MAPPED_OK:
    assert property (psel && penable && paddr == A_CTRL |-> !pslverr)
    else $error("error response on a mapped register");
  AST_UNMAPPED_ERR:
    assert property (psel && penable && paddr == 8'hFC |-> pslverr)
    else $error("no error response on an unmapped address");
  AST_MAX_CLAMP:
    assert property (speed_setpoint_out <= 16'sh1964 && speed_setpoint_out >= -16'sh1964)
    else $error("speed setpoint beyond the frequency ceiling");
  AST_INHIBIT_POS:
    assert property (cmd_in.negative_setpoint_inhibit [*8] |=> !speed_setpoint_out[15])
    else $error("negative speed setpoint while inhibited");
  AST_ENABLE_ZERO:
    assert property (!cmd_in.ramp_enable_input [*8] |=> speed_setpoint_out == 16'sh0000)
    else $error("ramp output not zero with enable low");
  AST_PULSES_IDLE:
    assert property (!cmd_in.pulses_enabled [*8] |=> speed_setpoint_out == 16'sh0000)
    else $error("ramp active without pulses");
  AST_RUN_FREEZE:
    assert property ((!cmd_in.ramp_run_input && cmd_in.ramp_enable_input
      && cmd_in.pulses_enabled && $stable(cmd_in)) [*8] |=> $stable(speed_setpoint_out))
    else $error("ramp output moved while run is low");
endmodule
bind dsc_top dsc_checker u_chk
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .cmd_in(cmd_in),
  .speed_setpoint_out(speed_setpoint_out)
);

// File: sim/dsc_partner.sv
// Model of the setpoint sources and feedback that feed the channel.
`timescale 1ns/1ps
module dsc_partner
(
  input wire logic pclk,
  input wire logic signed [15:0] main_tgt,
  input wire logic signed [15:0] supp_tgt,
  output dsc_pkg::dsc_rl_s raise_lower,
  output logic signed [15:0] main_sp,
  output logic signed [15:0] supp_sp,
  output logic signed [15:0] lsupp_sp,
  output logic signed [15:0] lfb
);
  import dsc_pkg::*;
  initial
  begin
    raise_lower = '0;
    main_sp = ZERO;
    supp_sp = ZERO;
    lsupp_sp = ZERO;
    lfb = ZERO;
  end
  // Sources move only after a clock edge; loop values wander at random.
  always @(posedge pclk)
  begin
    main_sp <= main_tgt;
    supp_sp <= supp_tgt;
    lsupp_sp <= 16'($urandom_range(200));
    lfb <= 16'($urandom_range(2000));
    raise_lower <= 2'($urandom_range(3));
  end
endmodule

// File: sim/drive_setpoint_channel_tb.sv
// Self-checking testbench of the drive setpoint channel.
`timescale 1ns/1ps
module drive_setpoint_channel_tb;
  import dsc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dsc_cmd_s cmd = '0;
  dsc_rl_s rl;
  logic [2:0] fix_sel = 3'h0;
  logic signed [15:0] main_tgt = 16'sh0000;
  logic signed [15:0] supp_tgt = 16'sh0000;
  logic signed [15:0] main_sp, supp_sp, lsupp_sp, lfb, speed, lout, fixed_sp;
  logic signed [15:0] prev = 16'sh0000;
  logic signed [15:0] frz;
  logic [15:0] fv;
  logic [31:0] rd;
  logic err;
  logic rate_on = 1'b0;
  logic [15:0] mf_in [4] = '{16'hFFFF, 16'h1965, 16'h1964, 16'h0064};
  logic [15:0] mf_exp [4] = '{16'h1964, 16'h1964, 16'h1964, 16'h0064};
  int error_cnt = 0;
  int cmp_count = 0;
  always #2.5 pclk = ~pclk;
  dsc_top #(.TICK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_in(cmd), .raise_lower_in(rl),
    .fix_sel_in(fix_sel), .main_setpoint(main_sp), .supp_setpoint(supp_sp),
    .loop_supp_setpoint(lsupp_sp), .loop_feedback(lfb), .speed_setpoint_out(speed),
    .loop_output(lout), .chosen_fixed_loop_setpoint(fixed_sp));
  dsc_partner u_partner (.pclk(pclk), .main_tgt(main_tgt), .supp_tgt(supp_tgt),
    .raise_lower(rl), .main_sp(main_sp), .supp_sp(supp_sp), .lsupp_sp(lsupp_sp),
    .lfb(lfb));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; an idle edge first keeps back-to-back calls clean.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      error_cnt++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_speed(input string name, input logic signed [15:0] exp);
    int n;
    n = 0;
    while (speed !== exp && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(name, speed, exp);
    if (n >= 2000)
      report_and_stop();
  endtask
  task automatic wait_loop(input string name, input logic signed [15:0] exp);
    int n;
    n = 0;
    while (lout !== exp && n < 4000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(name, lout, exp);
    if (n >= 4000)
      report_and_stop();
  endtask
  // While rate_on is set, any change larger than one ramp step between cycles is a mismatch.
  always @(posedge pclk)
  begin
    if (rate_on && (speed - prev > 5 || prev - speed > 5))
      chk("ramp_rate", 32'(speed - prev), 32'h0000_0005);
    prev <= speed;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'hfd53cb1a));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl_reset", rd, RST_CTRL);
    apb(1'b0, A_MAIN_SCALE, 32'h0);
    chk("main_scale_reset", rd, 32'(RST_SCALE));
    apb(1'b0, A_MAXF, 32'h0);
    chk("maxf_reset", rd, {16'h0000, RST_MAXF});
    apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    chk("unmapped_wr_err", err, 1'b1);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped_rd_err", err, 1'b1);
    chk("unmapped_rd_data", rd, 32'h0);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl_kept", rd, RST_CTRL);
    apb(1'b1, A_ROUND, 32'h1122_3344);
    apb(1'b0, A_ROUND, 32'h0);
    chk("round_trip", rd, 32'h1122_3344);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, A_MAXF, {16'h0000, mf_in[i]});
      apb(1'b0, A_MAXF, 32'h0);
      chk("maxf_saturation", rd, {16'h0000, mf_exp[i]});
    end
    $display("test max_frequency done");
    apb(1'b1, A_ACCEL, 32'h5);
    apb(1'b1, A_DECEL, 32'h5);
    apb(1'b1, A_ROUND, 32'h0);
    apb(1'b1, A_EXCIT, 32'h2);
    main_tgt <= 16'(200 + $urandom_range(1800));
    cmd <= 8'b1110_0001;
    repeat (40) @(posedge pclk);
    chk("no_pulses_idle", speed, 32'h0);
    cmd.pulses_enabled <= 1'b1;
    rate_on <= 1'b1;
    wait_speed("speed_clamped", 16'sd100);
    main_tgt <= 16'sd60;
    wait_speed("speed_decel", 16'sd60);
    cmd.reverse <= 1'b1;
    wait_speed("speed_reversed", -16'sd60);
    // The inhibit clamps a negative output to zero at once, outside the rate limit.
    rate_on <= 1'b0;
    cmd.negative_setpoint_inhibit <= 1'b1;
    repeat (60) @(posedge pclk);
    chk("inhibit_sign", speed[15], 1'b0);
    rate_on <= 1'b1;
    cmd <= 8'b1110_0111;
    wait_speed("supp_connected", 16'sd60);
    supp_tgt <= 16'sd30;
    wait_speed("supp_sum", 16'sd90);
    apb(1'b1, A_MAIN_SCALE, 32'h0000_0080);
    wait_speed("main_scaled", 16'sd60);
    cmd.supp_connect <= 1'b0;
    wait_speed("supp_removed", 16'sd30);
    $display("test setpoint_path done");
    cmd.ramp_setpoint_enable_input <= 1'b0;
    repeat (6) @(posedge pclk);
    cmd.ramp_run_input <= 1'b0;
    repeat (8) @(posedge pclk);
    frz = speed;
    repeat (40) @(posedge pclk);
    chk("run_freeze", speed, frz);
    chk("freeze_nonzero", frz == 16'sh0000, 1'b0);
    cmd.ramp_run_input <= 1'b1;
    wait_speed("setpoint_off_ramp", 16'sd0);
    cmd.ramp_setpoint_enable_input <= 1'b1;
    wait_speed("setpoint_on_ramp", 16'sd30);
    rate_on <= 1'b0;
    cmd.ramp_enable_input <= 1'b0;
    repeat (12) @(posedge pclk);
    chk("enable_low_zero", speed, 32'h0);
    cmd.ramp_enable_input <= 1'b1;
    $display("test ramp_controls done");
    fv = 16'($urandom_range(16'h0FFF));
    apb(1'b1, A_FIX0, {16'h0000, fv});
    fix_sel <= 3'b001;
    repeat (20) @(posedge pclk);
    chk("fixed_setpoint", fixed_sp, {16'h0000, fv});
    $display("test fixed_setpoint done");
    apb(1'b1, A_LP_LRT, 32'h0000_7FFF);
    apb(1'b1, A_LP_LIM, 32'hFFCE_0032);
    apb(1'b1, A_LP_RAMP, 32'h0100_0100);
    apb(1'b1, A_FIX0, 32'h0000_7000);
    apb(1'b1, A_CTRL, RST_CTRL | 32'h3);
    repeat (40) @(posedge pclk);
    chk("loop_enable_deferred", lout, 32'h0);
    cmd.run_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
    cmd.run_cmd <= 1'b1;
    wait_loop("loop_upper_clamp", 16'sd50);
    apb(1'b1, A_FIX0, 32'h0000_9000);
    wait_loop("loop_lower_clamp", -16'sd50);
    apb(1'b0, A_SRC_OUT, 32'h0);
    chk("loop_source_sign", rd[31], 1'b0);
    $display("test loop_controller done");
    fv = 16'($urandom_range(16'h0FFF));
    apb(1'b1, A_FIX0 + 8'h08, {16'h0000, fv});
    apb(1'b1, A_LP_FIXSEL, 32'h0000_002A);
    fix_sel <= 3'b011;
    repeat (20) @(posedge pclk);
    chk("fixed_binary", fixed_sp, {16'h0000, fv});
    apb(1'b1, A_LP_FIXSEL, 32'h0000_0001);
    fix_sel <= 3'b001;
    cmd.run_cmd <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("fixed_direct_on_idle", fixed_sp, 32'h0);
    $display("test fixed_select_modes done");
    report_and_stop();
  end
endmodule
